// *** spm_port.sv ***
`timescale 1ns/1ps
`default_nettype none
module spm_port
  import spm_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire spm_pin_in_s pins_in,
  input  wire logic        timer_two_output,
  output logic             sck_o,
  output logic             sck_oe_n,
  output logic             serial_out_pin_o,
  output logic             serial_out_pin_oe_n,
  output logic             serial_irq_o
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  spm_state_s r;
  spm_state_s n;

  logic       is_master;
  logic       sel_ctl;
  logic       sdi_v;
  logic       sck_v;
  logic       sck_p;
  logic       sel_hi;
  logic       busy;
  logic       acc;
  logic       wr;
  logic       rd;
  logic       load;
  logic       done_byte;
  logic       tick;
  logic       drive_e;
  logic       samp_e;
  logic       lead;
  logic       trail;
  logic [4:0] edge_n;
  logic [9:0] half_m1;
  logic [7:0] rd_byte;
  logic       unmapped;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    n         = r;
    load      = 1'b0;
    done_byte = 1'b0;
    tick      = 1'b0;
    drive_e   = 1'b0;
    samp_e    = 1'b0;
    edge_n    = r.ec + 5'h01;

    // pins from outside: two flops before any use; third stage only for edges
    n.sck_sy = {r.sck_sy[1:0], pins_in.sck};
    n.sdi_sy = {r.sdi_sy[0], pins_in.serial_in_pin};
    n.sel_sy = {r.sel_sy[0], pins_in.sel_n};
    sck_v    = r.sck_sy[1];
    sck_p    = r.sck_sy[2];
    sdi_v    = r.sdi_sy[1];
    sel_hi   = r.sel_sy[1];

    is_master = (r.mode != MODE_S_SEL) && (r.mode != MODE_S_NOSEL);
    sel_ctl   = (r.mode == MODE_S_SEL);
    busy      = is_master ? (r.st == ST_RUN) : (r.bc != 4'h0);
    lead      = (sck_v != r.clock_idle_level) && (sck_p == r.clock_idle_level);
    trail     = (sck_v == r.clock_idle_level) && (sck_p != r.clock_idle_level);

    case (r.mode)
      MODE_M_DIV4:  half_m1 = HALF_M1_DIV4;
      MODE_M_DIV16: half_m1 = HALF_M1_DIV16;
      MODE_M_DIV64: half_m1 = HALF_M1_DIV64;
      MODE_M_BAUD:  half_m1 = {1'b0, r.baud, 1'b1};
      default:      half_m1 = HALF_M1_DIV4;
    endcase

    // ----------------------------------------
    // apb slave: one wait state, answer from flops
    // ----------------------------------------
    acc      = psel && penable && r.pready;
    wr       = acc && pwrite;
    rd       = acc && !pwrite;
    n.pready = psel && penable && !r.pready;

    unmapped = 1'b0;
    case (paddr)
      ADDR_CTRL1: rd_byte = {r.write_collision_flag, r.ovf, r.en, r.clock_idle_level, r.mode};
      ADDR_STAT:  rd_byte = {r.input_sample_phase, r.cke, 5'h00, r.bf};
      ADDR_CTRL3: rd_byte = {3'h0, r.buffer_overwrite_enable, 4'h0};
      ADDR_BUF:   rd_byte = r.buf_q;
      ADDR_BAUD:  rd_byte = r.baud;
      ADDR_EVT:   rd_byte = {6'h00, r.irq_en, r.irq_flag};
      default: begin
        rd_byte  = 8'h00;
        unmapped = 1'b1;
      end
    endcase
    if (psel && penable && !r.pready) begin
      n.prdata  = pwrite ? 8'h00 : rd_byte;
      n.pslverr = unmapped;
    end else begin
      n.pslverr = 1'b0;
    end

    if (wr) begin
      case (paddr)
        ADDR_CTRL1: begin
          // flags clear on a written zero; software cannot raise them
          n.write_collision_flag = r.write_collision_flag & pwdata[CTRL1_WRITE_COLLISION_FLAG];
          n.ovf  = r.ovf & pwdata[CTRL1_OVF];
          n.en   = pwdata[CTRL1_EN];
          n.clock_idle_level  = pwdata[CTRL1_CKP];
          n.mode = pwdata[3:0];
        end
        ADDR_STAT: begin
          n.input_sample_phase = pwdata[STAT_SMP];
          n.cke = pwdata[STAT_CKE];
        end
        ADDR_CTRL3: n.buffer_overwrite_enable = pwdata[CTRL3_BUFFER_OVERWRITE_ENABLE];
        ADDR_BUF: begin
          if (busy) begin
            n.write_collision_flag = 1'b1;
          end else if (!r.write_collision_flag && (!r.bf || r.buffer_overwrite_enable)) begin
            load      = 1'b1;
            n.buf_q   = pwdata[7:0];
            n.shifter = pwdata[7:0];
            n.sdo_o   = pwdata[MSB];
          end
        end
        ADDR_BAUD: n.baud = pwdata[7:0];
        ADDR_EVT: begin
          n.irq_flag = r.irq_flag & ~pwdata[EVT_IRQ];
          n.irq_en   = pwdata[EVT_IE];
        end
        default: ;
      endcase
    end
    if (rd && (paddr == ADDR_BUF)) begin
      n.bf = 1'b0;
    end

    // ----------------------------------------
    // shift engine
    // ----------------------------------------
    if (!r.en) begin
      // disabled: counters forced to zero, pins released
      n.st       = ST_IDLE;
      n.ec       = 5'h00;
      n.bc       = 4'h0;
      n.pend     = 1'b0;
      n.div      = 10'h000;
      n.sck_o    = r.clock_idle_level;
      n.sck_oe_n = 1'b1;
      n.sdo_oe_n = 1'b1;
    end else if (is_master) begin
      n.sck_oe_n = 1'b0;
      n.sdo_oe_n = 1'b0;
      case (r.st)
        ST_IDLE: begin
          n.sck_o = r.clock_idle_level;
          if (load) begin
            n.st   = ST_RUN;
            n.ec   = 5'h00;
            n.bc   = 4'h0;
            n.pend = 1'b0;
            n.div  = half_m1;
          end
        end
        ST_RUN: begin
          if (r.mode == MODE_M_TMR2) begin
            tick = timer_two_output;
          end else begin
            tick  = (r.div == 10'h000);
            n.div = tick ? half_m1 : r.div - 10'h001;
          end
          if (tick) begin
            n.ec = edge_n;
            if (r.ec < EDGES_BYTE) begin
              n.sck_o = ~r.sck_o;
            end
            // pending late sample takes the input before the output moves
            if (r.pend) begin
              n.pend    = 1'b0;
              n.shifter = {n.shifter[6:0], sdi_v};
              n.bc      = r.bc + 4'h1;
              done_byte = (n.bc == BITS_BYTE);
            end
            if (edge_n <= EDGES_BYTE) begin
              drive_e = edge_n[0] ^ r.cke;
              if (drive_e) begin
                n.sdo_o = n.shifter[MSB];
              end else if (r.input_sample_phase) begin
                n.pend = 1'b1;
              end else begin
                n.shifter = {n.shifter[6:0], sdi_v};
                n.bc      = r.bc + 4'h1;
                done_byte = (n.bc == BITS_BYTE);
              end
            end
            if ((n.bc == BITS_BYTE) && (edge_n >= EDGES_BYTE) && !n.pend) begin
              n.st    = ST_IDLE;
              n.sck_o = r.clock_idle_level;
            end
          end
        end
        default: n.st = ST_IDLE;
      endcase
    end else begin
      n.sck_oe_n = 1'b1;
      n.sck_o    = r.clock_idle_level;
      n.st       = ST_IDLE;
      if (sel_ctl && sel_hi) begin
        n.bc       = 4'h0;
        n.sdo_oe_n = 1'b1;
      end else begin
        n.sdo_oe_n = 1'b0;
        samp_e     = r.cke ? lead : trail;
        drive_e    = r.cke ? trail : lead;
        if (samp_e) begin
          // shifter keeps the byte, so the next group repeats it
          n.shifter = {n.shifter[6:0], sdi_v};
          n.bc      = r.bc + 4'h1;
          if (n.bc == BITS_BYTE) begin
            done_byte = 1'b1;
            n.bc      = 4'h0;
          end
        end
        if (drive_e) begin
          n.sdo_o = n.shifter[MSB];
        end
      end
    end

    // ----------------------------------------
    // byte completion: hardware sets win over software clears
    // ----------------------------------------
    if (done_byte) begin
      if (r.bf && !r.buffer_overwrite_enable) begin
        n.ovf = 1'b1;
      end else begin
        n.buf_q = n.shifter;
      end
      n.bf       = 1'b1;
      n.irq_flag = 1'b1;
    end
    // no gate on pclk here, so a slave byte still flags the wake request
    n.irq_o = n.irq_flag & n.irq_en;
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.sck_oe_n <= 1'b1;
      r.sdo_oe_n <= 1'b1;
      r.st       <= ST_IDLE;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign prdata              = {24'h00_0000, r.prdata};
  assign pready              = r.pready;
  assign pslverr             = r.pslverr;
  assign sck_o               = r.sck_o;
  assign sck_oe_n            = r.sck_oe_n;
  assign serial_out_pin_o    = r.sdo_o;
  assign serial_out_pin_oe_n = r.sdo_oe_n;
  assign serial_irq_o        = r.irq_o;

endmodule
`default_nettype wire

// *** spm_pkg.sv ***
// Summary of operation
// - control fields select role, idle clock level, sample phase, edge, rate, select use
// - port works only while port_enable set; clearing it resets the port; here only the shift engine resets, flags and buffer keep their values
// - shifter moves data msb first; full byte moves into transfer_buffer
// - byte moved into transfer_buffer sets buffer_full_flag and serial_irq_flag
// - buffer write while shifting is discarded and sets write_collision_flag
// - while write_collision_flag set, buffer writes do not complete
// - software read of transfer_buffer clears buffer_full_flag
// - receive is double buffered; next byte may shift before buffer read
// - master: buffer write starts an eight bit full duplex exchange at once
// - master receive-only: each byte still loads buffer with flags set
// - master rate: clock/4, /16, /64, timer two/2, or clock/(4*(baud_reload+1))
// - clock_edge_select set: output data valid before first clock edge
// - serial clock idle level follows clock_idle_level
// - input_sample_phase picks sample at middle or end of output time
// - master drives serial clock pin; slave takes it as input
// - slave shifts on external clock; irq flag set when last bit latched
// - slave keeps shifting while device sleeps; completed byte raises wake interrupt
// - daisy chain: slave shifts out exact copy of byte received before
// - buffer_overwrite_enable lets writes in though received byte unread
// - transfer_shifter is reached only through transfer_buffer
// - software reads buffer before next write and polls or uses interrupt
// - buffer write loads same value into buffer and shifter
// - data shifts out on programmed edge, latched on opposite edge
// - slave with select control: bit counter reset while select high
// - select high: serial output released at once, even mid byte; here on the third pclk edge after the pin rises
package spm_pkg;

  // ----------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] ADDR_CTRL1 = 8'h00;
  localparam logic [7:0] ADDR_STAT  = 8'h04;
  localparam logic [7:0] ADDR_CTRL3 = 8'h08;
  localparam logic [7:0] ADDR_BUF   = 8'h0C;
  localparam logic [7:0] ADDR_BAUD  = 8'h10;
  localparam logic [7:0] ADDR_EVT   = 8'h14;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CTRL1_WRITE_COLLISION_FLAG = 7;
  localparam int CTRL1_OVF  = 6;
  localparam int CTRL1_EN   = 5;
  localparam int CTRL1_CKP  = 4;
  localparam int STAT_SMP   = 7;
  localparam int STAT_CKE   = 6;
  localparam int CTRL3_BUFFER_OVERWRITE_ENABLE = 4;
  localparam int EVT_IRQ    = 0;
  localparam int EVT_IE     = 1;
  localparam int MSB        = 7;

  // ----------------------------------------
  // mode codes
  // ----------------------------------------
  localparam logic [3:0] MODE_M_DIV4  = 4'h0;
  localparam logic [3:0] MODE_M_DIV16 = 4'h1;
  localparam logic [3:0] MODE_M_DIV64 = 4'h2;
  localparam logic [3:0] MODE_M_TMR2  = 4'h3;
  localparam logic [3:0] MODE_S_SEL   = 4'h4;
  localparam logic [3:0] MODE_S_NOSEL = 4'h5;
  localparam logic [3:0] MODE_M_BAUD  = 4'hA;

  // ----------------------------------------
  // timing: divide ratios, half serial clock period minus one in pclk cycles, edges and bits per byte
  // ----------------------------------------
  localparam int          DIV4_RATIO    = 4;
  localparam int          DIV16_RATIO   = 16;
  localparam int          DIV64_RATIO   = 64;
  localparam logic [9:0]  HALF_M1_DIV4  = 10'(DIV4_RATIO / 2 - 1);
  localparam logic [9:0]  HALF_M1_DIV16 = 10'(DIV16_RATIO / 2 - 1);
  localparam logic [9:0]  HALF_M1_DIV64 = 10'(DIV64_RATIO / 2 - 1);
  localparam logic [4:0]  EDGES_BYTE    = 5'h10;
  localparam logic [3:0]  BITS_BYTE     = 4'h8;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01
  } spm_state_e;

  typedef struct packed {
    logic       sck;
    logic       serial_in_pin;
    logic       sel_n;
  } spm_pin_in_s;

  typedef struct packed {
    logic [7:0] prdata;
    logic       pready;
    logic       pslverr;
    logic       write_collision_flag;
    logic       ovf;
    logic       en;
    logic       clock_idle_level;
    logic [3:0] mode;
    logic       input_sample_phase;
    logic       cke;
    logic       bf;
    logic       buffer_overwrite_enable;
    logic       irq_flag;
    logic       irq_en;
    logic [7:0] buf_q;
    logic [7:0] shifter;
    logic [7:0] baud;
    spm_state_e st;
    logic [4:0] ec;
    logic [3:0] bc;
    logic [9:0] div;
    logic       pend;
    logic [2:0] sck_sy;
    logic [1:0] sdi_sy;
    logic [1:0] sel_sy;
    logic       sck_o;
    logic       sck_oe_n;
    logic       sdo_o;
    logic       sdo_oe_n;
    logic       irq_o;
  } spm_state_s;

endpackage

// *** spm_port_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module spm_port_props
  import spm_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire spm_pin_in_s pins_in,
  input wire logic        timer_two_output,
  input wire logic        sck_o,
  input wire logic        sck_oe_n,
  input wire logic        serial_out_pin_o,
  input wire logic        serial_out_pin_oe_n,
  input wire logic        serial_irq_o
);
  logic [5:0] ctl_r;
  logic       ie_r;
  logic       mst;
  logic       wr;
  assign wr  = psel && penable && pready && pwrite;
  assign mst = ctl_r[5] && ctl_r[3:0] != MODE_S_SEL && ctl_r[3:0] != MODE_S_NOSEL;
  // shadow of control bits; outputs may lag one cycle, hence the [*2]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_r <= '0;
      ie_r  <= 1'b0;
    end else if (wr && paddr == ADDR_CTRL1) begin
      ctl_r <= pwdata[5:0];
    end else if (wr && paddr == ADDR_EVT) begin
      ie_r <= pwdata[EVT_IE];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable ##1 psel && penable;
  endsequence
  sequence s_sel_off;
    ctl_r[5] && ctl_r[3:0] == MODE_S_SEL && $rose(pins_in.sel_n);
  endsequence
  a_sck_driven: assert property (mst [*2] |-> !sck_oe_n) else $error("clock not driven");
  a_sck_released: assert property (!mst [*2] |-> sck_oe_n) else $error("clock driven");
  a_out_disabled: assert property (!ctl_r[5] [*2] |-> serial_out_pin_oe_n) else $error("out driven");
  a_irq_masked: assert property (!ie_r [*2] |-> !serial_irq_o) else $error("irq unmasked");
  a_sel_release: assert property (s_sel_off |-> ##[1:4] serial_out_pin_oe_n) else $error("out held");
  a_ready_wait: assert property (s_setup |-> !pready ##1 pready) else $error("ready timing");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
  a_bad_addr: assert property (pready && paddr > ADDR_EVT |-> pslverr && prdata == '0) else $error("bad addr");
  a_byte_wide: assert property (pready |-> prdata[31:8] == '0) else $error("upper bits");
endmodule
bind spm_port spm_port_props spm_port_props_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .pins_in, .timer_two_output, .sck_o, .sck_oe_n, .serial_out_pin_o,
  .serial_out_pin_oe_n, .serial_irq_o);
`default_nettype wire

// *** spm_partner.sv ***
`timescale 1ns/1ps
`default_nettype none
module spm_partner (
  input  wire logic       sck,
  input  wire logic       sel_n,
  input  wire logic       mosi,
  input  wire logic [7:0] tx_byte,
  output logic            miso,
  output logic [7:0]      rx_byte
);
  logic [7:0] sh;
  logic       hold;
  initial begin
    sh = 8'h00;
    hold = 1'b0;
    rx_byte = 8'h00;
  end
  // released line shows the inverse of its last bit, never a stale copy
  always @(negedge sel_n) sh = tx_byte;
  always @(posedge sel_n) hold = ~sh[7];
  always @(posedge sck) if (!sel_n) rx_byte = {rx_byte[6:0], mosi};
  always @(negedge sck) if (!sel_n) sh = {sh[6:0], 1'b0};
  assign miso = sel_n ? hold : sh[7];
endmodule
`default_nettype wire

// *** tb_spi_master_slave_port.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_spi_master_slave_port
  import spm_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, tmr, slv, t_sck, t_sdi, t_sel_n, p_sel_n;
  logic        pready, pslverr, sck_o, sck_oe_n, serial_out_pin, sdo_oe_n, irq, p_miso, err;
  logic [7:0]  paddr, p_tx, p_rx, got;
  logic [31:0] pwdata, prdata, q;
  spm_pin_in_s pins;
  int          error_cnt, n_checks, tc, n, h;
  logic [3:0]  modes [5] = '{MODE_M_DIV4, MODE_M_DIV16, MODE_M_DIV64, MODE_M_TMR2, MODE_M_BAUD};
  int          halfs [5] = '{DIV4_RATIO / 2, DIV16_RATIO / 2, DIV64_RATIO / 2, 5, 2 * (3 + 1)};
  assign pins = {slv ? t_sck : sck_o, slv ? t_sdi : p_miso, slv ? t_sel_n : 1'b1};
  spm_port spm_port_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .pins_in(pins), .timer_two_output(tmr), .sck_o, .sck_oe_n, .serial_out_pin_o(serial_out_pin),
    .serial_out_pin_oe_n(sdo_oe_n), .serial_irq_o(irq));
  spm_partner spm_partner_inst (.sck(sck_o), .sel_n(p_sel_n), .mosi(serial_out_pin), .tx_byte(p_tx), .miso(p_miso),
    .rx_byte(p_rx));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // timer pulse every fifth cycle
  always @(posedge pclk) begin
    tc <= (tc == 4) ? 0 : tc + 1;
    tmr <= (tc == 4);
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) begin
      error_cnt++;
      summarize();
    end
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, e, q);
  endtask
  task automatic wait_irq();
    int k;
    k = 0;
    do begin
      apb(1'b0, ADDR_EVT, 32'h0000_0000);
      k++;
    end while (q[EVT_IRQ] !== 1'b1 && k < 400);
    if (k >= 400) begin
      error_cnt++;
      summarize();
    end
  endtask
  // external master: data set with the leading edge, device output taken late in the bit
  task automatic sbyte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      t_sdi <= b[i];
      t_sck <= 1'b1;
      repeat (4) @(posedge pclk);
      t_sck <= 1'b0;
      repeat (4) @(posedge pclk);
      got = {got[6:0], serial_out_pin};
    end
  endtask
  initial begin
    {psel, penable, pwrite, t_sck, t_sdi, slv, tmr, presetn} = '0;
    {t_sel_n, p_sel_n} = 2'b11;
    {paddr, pwdata, p_tx, got} = '0;
    {error_cnt, n_checks, tc} = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(ADDR_CTRL1, 32'h0000_0000, "ctrl1 reset");
    rd(8'h18, 32'h0000_0000, "unmapped");
    chk("unmapped err", 32'h0000_0001, {31'h0, err});
    $display("test reset done");
    apb(1'b1, ADDR_CTRL1, 32'h0000_0021);
    apb(1'b1, ADDR_STAT, 32'h0000_0040);
    p_tx <= 8'h3C;
    p_sel_n <= 1'b0;
    apb(1'b1, ADDR_BUF, 32'h0000_00A5);
    apb(1'b1, ADDR_BUF, 32'h0000_0011);
    rd(ADDR_CTRL1, 32'h0000_00A1, "collision");
    wait_irq();
    chk("partner rx", 32'h0000_00A5, {24'h0, p_rx});
    rd(ADDR_STAT, 32'h0000_0041, "full set");
    rd(ADDR_BUF, 32'h0000_003C, "master rx");
    rd(ADDR_STAT, 32'h0000_0040, "full clear");
    apb(1'b1, ADDR_EVT, 32'h0000_0001);
    apb(1'b1, ADDR_BUF, 32'h0000_0077);
    repeat (200) @(posedge pclk);
    rd(ADDR_EVT, 32'h0000_0000, "blocked write");
    apb(1'b1, ADDR_CTRL1, 32'h0000_0021);
    p_sel_n <= 1'b1;
    p_tx <= 8'hC3;
    @(posedge pclk);
    p_sel_n <= 1'b0;
    apb(1'b1, ADDR_BUF, 32'h0000_0077);
    wait_irq();
    chk("partner rx 2", 32'h0000_0077, {24'h0, p_rx});
    rd(ADDR_BUF, 32'h0000_00C3, "master rx 2");
    $display("test master done");
    apb(1'b1, ADDR_CTRL3, 32'h0000_0010);
    apb(1'b1, ADDR_BAUD, 32'h0000_0003);
    foreach (modes[i]) begin
      apb(1'b1, ADDR_EVT, 32'h0000_0001);
      apb(1'b1, ADDR_CTRL1, {24'h0, 4'h2, modes[i]});
      apb(1'b1, ADDR_BUF, 32'h0000_0000);
      n = 0;
      while (sck_o !== 1'b1 && n < 300) begin
        @(posedge pclk);
        n++;
      end
      h = 0;
      while (sck_o === 1'b1 && h < 300) begin
        @(posedge pclk);
        h++;
      end
      chk("sck start", 32'h0000_0001, {31'h0, n < 300});
      chk("half period", 32'(halfs[i]), 32'(h));
      wait_irq();
      // let the last half period of the byte end before the next buffer write
      repeat (80) @(posedge pclk);
    end
    $display("test rates done");
    apb(1'b1, ADDR_CTRL1, 32'h0000_0000);
    apb(1'b1, ADDR_STAT, 32'h0000_0000);
    apb(1'b1, ADDR_CTRL3, 32'h0000_0000);
    // drain the last rate byte so the slave byte is not refused as overflow
    apb(1'b0, ADDR_BUF, 32'h0000_0000);
    slv <= 1'b1;
    apb(1'b1, ADDR_CTRL1, 32'h0000_0024);
    apb(1'b1, ADDR_EVT, 32'h0000_0003);
    t_sel_n <= 1'b0;
    repeat (4) @(posedge pclk);
    sbyte(8'h96);
    repeat (6) @(posedge pclk);
    chk("wake irq", 32'h0000_0001, {31'h0, irq});
    rd(ADDR_BUF, 32'h0000_0096, "slave rx");
    sbyte(8'h5A);
    chk("chain copy", 32'h0000_0096, {24'h0, got});
    t_sel_n <= 1'b1;
    repeat (5) @(posedge pclk);
    chk("out released", 32'h0000_0001, {31'h0, sdo_oe_n});
    $display("test slave done");
    summarize();
  end
endmodule
`default_nettype wire
